/* pkg/ldm_defs.svh */
`ifndef LDM_DEFS_SVH
`define LDM_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define LDM_A_TCTL  5'h16
`define LDM_A_TWIN  5'h17
`define LDM_A_TPEAK 5'h18
`define LDM_A_TTHR  5'h19
`define LDM_A_VCTL  5'h1A
`define LDM_A_VDATA 5'h1B
`define LDM_A_LQM2  5'h1C
`define LDM_A_LQM   5'h1D
`define LDM_A_LQD   5'h1E
// ****************************************
// Field positions
// ****************************************
`define LDM_TC_EN     15
`define LDM_TC_FAST   14
`define LDM_TC_TXRX   13
`define LDM_TC_MONRX  12
`define LDM_TC_SEND   11
`define LDM_TC_MIN    7
`define LDM_VC_EN     15
`define LDM_VC_DONE   14
`define LDM_LQ_EN     15
`define LDM_LQ_SAMPLE 13
`define LDM_LQ_WR     12
`define LDM_LQM2_VW   0
`define LDM_GAIN_IDX  1
`define LDM_VAR_SEL   3'h5
// ****************************************
// Reset values
// ****************************************
`define LDM_WIN_RST  16'h00FF
`define LDM_VHI_RST  16'h0900
`define LDM_SMIN     8'h80
`define LDM_SMAX     8'h7F
`define LDM_UMIN     8'h00
`define LDM_UMAX     8'hFF
// ****************************************
// Timing
// ****************************************
`define LDM_CLK_NS        10
`define LDM_MS_NS         1000000
`define LDM_SLOW_SHORT_NS 50
`define LDM_SLOW_LONG_NS  100
`define LDM_FAST_STEP_NS  8
`define LDM_MSC_W         24
`endif

/* pkg/ldm_pkg.sv */
`include "ldm_defs.svh"
package ldm_pkg;
    typedef enum logic {TDR_IDLE, TDR_RUN} ldm_tdr_t;

    typedef struct packed {
        logic [15:0]           rdata;
        logic [15:0]           tctl;
        logic [15:0]           twin;
        logic [7:0]            tthr;
        ldm_tdr_t              ts;
        logic [7:0]            tmr;
        logic [7:0]            peak;
        logic [7:0]            peak_t;
        logic                  found;
        logic [7:0]            cross_t;
        logic [3:0]            pcnt;
        logic                  pol;
        logic                  dslow;
        logic                  dpos;
        logic                  dneg;
        logic                  ven;
        logic [1:0]            vsel;
        logic                  vdone;
        logic [`LDM_MSC_W-1:0] msc;
        logic [2:0]            ms;
        logic [31:0]           acc;
        logic [31:0]           vsum;
        logic [31:0]           vsnap;
        logic                  vhalf;
        logic                  lq_en;
        logic [9:0]            warn;
        logic                  vwarn;
        logic [5:0]            auto;
        logic [4:0][7:0]       lo;
        logic [4:0][7:0]       hi;
        logic [15:0]           vhi;
        logic [7:0]            lqd;
        logic                  irq;
        logic                  trg;
        logic                  restart;
        logic                  drop;
    } ldm_state_t;
endpackage : ldm_pkg

/* rtl/ldm_monitor.sv */
`include "ldm_defs.svh"
module ldm_monitor #(
    parameter int MS_CYC = `LDM_MS_NS / `LDM_CLK_NS
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic      [15:0] reg_rdata,
    input  wire logic [7:0]  rx_err_sq,
    input  wire logic [7:0]  equalizer_coefficient,
    input  wire logic [7:0]  adaptive_gain,
    input  wire logic [7:0]  baseline_wander,
    input  wire logic [7:0]  long_term_frequency_offset,
    input  wire logic [7:0]  frequency_control_value,
    input  wire logic [7:0]  adc_sample,
    input  wire logic        signal_detect_option,
    output logic             tdr_owns_drivers,
    output logic             slow_line_driver,
    output logic             fast_line_driver_pos,
    output logic             fast_line_driver_neg,
    output logic             pulse_on_rx_pair,
    output logic             monitor_rx_pair,
    output logic             adapt_restart,
    output logic             link_drop,
    output logic             lq_irq
);
    import ldm_pkg::*;

    localparam int SLOW_S = (`LDM_SLOW_SHORT_NS + `LDM_CLK_NS - 1) / `LDM_CLK_NS;
    localparam int SLOW_L = (`LDM_SLOW_LONG_NS + `LDM_CLK_NS - 1) / `LDM_CLK_NS;
    localparam int FSTEP  = (`LDM_FAST_STEP_NS + `LDM_CLK_NS - 1) / `LDM_CLK_NS;

    ldm_state_t      r;
    ldm_state_t      n;
    logic [4:0][7:0] pv;
    logic [4:0]      lo_v;
    logic [4:0]      hi_v;
    logic [9:0]      warn_now;
    logic [15:0]     vpar;
    logic            vhi_v;
    logic [5:0]      viol;
    logic [2:0]      wsel;
    logic [2:0]      wdth;
    logic            win;
    logic            start;
    logic            vend;

    assign pv   = {frequency_control_value, long_term_frequency_offset,
                   baseline_wander, adaptive_gain, equalizer_coefficient};
    // Variance parameter is the upper half of the latched sum
    assign vpar  = r.vsum[31:16];
    assign vhi_v = vpar > r.vhi;
    assign wsel  = reg_wdata[11:9];
    assign wdth  = reg_wdata[10:8];
    assign win   = (r.tmr >= r.twin[15:8]) && (r.tmr <= r.twin[7:0]);
    assign start = reg_we && (reg_addr == `LDM_A_TCTL)
                 && reg_wdata[`LDM_TC_SEND] && reg_wdata[`LDM_TC_EN];
    assign vend  = r.ven && (r.msc == `LDM_MSC_W'(MS_CYC - 1)) && (r.ms == {r.vsel, 1'b1});

    // ****************************************
    // Threshold comparators
    // ****************************************
    genvar gi;
    for (gi = 0; gi < 5; gi++) begin : g_cmp
        if (gi == `LDM_GAIN_IDX) begin : g_u
            assign lo_v[gi] = pv[gi] < r.lo[gi];
            assign hi_v[gi] = pv[gi] > r.hi[gi];
        end else begin : g_s
            assign lo_v[gi] = $signed(pv[gi]) < $signed(r.lo[gi]);
            assign hi_v[gi] = $signed(pv[gi]) > $signed(r.hi[gi]);
        end
        assign warn_now[2*gi]   = lo_v[gi];
        assign warn_now[2*gi+1] = hi_v[gi];
        assign viol[gi]         = lo_v[gi] | hi_v[gi];
    end
    assign viol[5] = vhi_v;

    always_comb begin
        n         = r;
        n.restart = 1'b0;
        n.drop    = 1'b0;
        // ****************************************
        // Variance accumulator
        // ****************************************
        if (r.ven) begin
            n.acc = r.acc + 32'(rx_err_sq);
            if (r.msc == `LDM_MSC_W'(MS_CYC - 1)) begin
                n.msc = '0;
                n.ms  = r.ms + 3'h1;
                if (r.ms == {r.vsel, 1'b1}) begin
                    n.ms    = '0;
                    n.vsum  = n.acc;
                    n.acc   = '0;
                    n.vdone = 1'b1;
                end
            end else begin
                n.msc = r.msc + `LDM_MSC_W'(1);
            end
        end
        // ****************************************
        // Reflectometry monitor
        // ****************************************
        if (r.pcnt != 4'h0) begin
            n.pcnt = r.pcnt - 4'h1;
        end
        case (r.ts)
            TDR_IDLE: begin
            end
            TDR_RUN: begin
                n.tmr = r.tmr + 8'h01;
                if (win) begin
                    if (r.tctl[`LDM_TC_MIN] ? ($signed(adc_sample) < $signed(r.peak))
                                            : ($signed(adc_sample) > $signed(r.peak))) begin
                        n.peak   = adc_sample;
                        n.peak_t = r.tmr;
                    end
                    if (!r.found && (r.tctl[`LDM_TC_MIN]
                            ? ($signed(adc_sample) < $signed(r.tthr))
                            : ($signed(adc_sample) > $signed(r.tthr)))) begin
                        n.found   = 1'b1;
                        n.cross_t = r.tmr;
                    end
                end
                // Timer halts at stop so results stay put for software
                if ((r.tmr == r.twin[7:0]) || !r.tctl[`LDM_TC_EN]) begin
                    n.ts = TDR_IDLE;
                end
            end
            default: n.ts = TDR_IDLE;
        endcase
        // ****************************************
        // Link quality monitor
        // ****************************************
        if (reg_re && (reg_addr == `LDM_A_LQM)) begin
            n.warn = '0;
            n.irq  = 1'b0;
        end
        if (reg_re && (reg_addr == `LDM_A_LQM2)) begin
            n.vwarn = 1'b0;
        end
        // Set after clear: a violation in the read cycle is kept
        if (r.lq_en) begin
            n.warn  = n.warn | warn_now;
            n.vwarn = n.vwarn | vhi_v;
            n.irq   = n.irq | (|viol);
        end
        n.trg = r.lq_en && |(viol & r.auto);
        if (n.trg && !r.trg) begin
            n.restart = 1'b1;
            n.drop    = !signal_detect_option;
        end
        // ****************************************
        // Register writes
        // ****************************************
        if (reg_we) begin
            case (reg_addr)
                `LDM_A_TCTL: begin
                    n.tctl = reg_wdata & ~(16'h0001 << `LDM_TC_SEND);
                    if (!reg_wdata[`LDM_TC_EN]) begin
                        n.pcnt = '0;
                    end
                    if (start) begin
                        n.ts      = TDR_RUN;
                        n.tmr     = '0;
                        n.found   = 1'b0;
                        n.peak_t  = '0;
                        n.cross_t = '0;
                        n.peak    = reg_wdata[`LDM_TC_MIN] ? `LDM_SMAX : `LDM_SMIN;
                        if (reg_wdata[`LDM_TC_FAST]) begin
                            n.pcnt = 4'(32'(wdth) * FSTEP);
                            n.pol  = ~r.pol;
                        end else if (wdth == 3'h0) begin
                            n.pcnt = '0;
                        end else begin
                            n.pcnt = wdth[2] ? 4'(SLOW_L) : 4'(SLOW_S);
                        end
                    end
                end
                `LDM_A_TWIN: n.twin = reg_wdata;
                `LDM_A_TTHR: n.tthr = reg_wdata[7:0];
                `LDM_A_VCTL: begin
                    n.ven  = reg_wdata[`LDM_VC_EN];
                    n.vsel = reg_wdata[1:0];
                    n.acc  = '0;
                    n.msc  = '0;
                    n.ms   = '0;
                end
                `LDM_A_LQM2: n.auto = reg_wdata[13:8];
                `LDM_A_LQM:  n.lq_en = reg_wdata[`LDM_LQ_EN];
                `LDM_A_LQD: begin
                    if (reg_wdata[`LDM_LQ_SAMPLE]) begin
                        n.lqd = (wsel == `LDM_VAR_SEL)
                              ? (reg_wdata[8] ? vpar[15:8] : vpar[7:0])
                              : ((wsel < 3'h5) ? pv[wsel] : 8'h00);
                    end else if (reg_wdata[`LDM_LQ_WR]) begin
                        if (wsel == `LDM_VAR_SEL) begin
                            if (reg_wdata[8]) begin
                                n.vhi[15:8] = reg_wdata[7:0];
                            end else begin
                                n.vhi[7:0] = reg_wdata[7:0];
                            end
                        end else if (wsel < 3'h5) begin
                            if (reg_wdata[8]) begin
                                n.hi[wsel] = reg_wdata[7:0];
                            end else begin
                                n.lo[wsel] = reg_wdata[7:0];
                            end
                        end
                    end else if (wsel == `LDM_VAR_SEL) begin
                        n.lqd = reg_wdata[8] ? r.vhi[15:8] : r.vhi[7:0];
                    end else if (wsel < 3'h5) begin
                        n.lqd = reg_wdata[8] ? r.hi[wsel] : r.lo[wsel];
                    end
                end
                default: begin
                end
            endcase
        end
        // ****************************************
        // Register reads
        // ****************************************
        if (reg_re) begin
            case (reg_addr)
                `LDM_A_TCTL:  n.rdata = r.tctl;
                `LDM_A_TWIN:  n.rdata = r.twin;
                `LDM_A_TPEAK: n.rdata = {r.peak_t, r.peak};
                `LDM_A_TTHR:  n.rdata = {r.cross_t, r.tthr};
                `LDM_A_VCTL: begin
                    n.rdata = {r.ven, r.vdone, 12'h000, r.vsel};
                    n.vdone = vend; // Period end in the read cycle must not be lost
                end
                `LDM_A_VDATA: begin
                    if (!r.vhalf) begin
                        n.vsnap = r.vsum;
                        n.rdata = r.vsum[15:0];
                    end else begin
                        n.rdata = r.vsnap[31:16];
                    end
                    n.vhalf = ~r.vhalf;
                end
                `LDM_A_LQM2: n.rdata = {2'h0, r.auto, 7'h00, r.vwarn};
                `LDM_A_LQM:  n.rdata = {r.lq_en, r.irq, 4'h0, r.warn};
                `LDM_A_LQD:  n.rdata = {8'h00, r.lqd};
                default:     n.rdata = 16'h0000;
            endcase
        end
        // Drivers follow the pulse counter, gated by reflectometry enable
        n.dslow = n.tctl[`LDM_TC_EN] && !n.tctl[`LDM_TC_FAST] && (n.pcnt != 4'h0);
        n.dpos  = n.tctl[`LDM_TC_EN] && n.tctl[`LDM_TC_FAST] && (n.pcnt != 4'h0) && n.pol;
        n.dneg  = n.tctl[`LDM_TC_EN] && n.tctl[`LDM_TC_FAST] && (n.pcnt != 4'h0) && !n.pol;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r       <= '0;
            r.twin  <= `LDM_WIN_RST;
            r.ts    <= TDR_IDLE;
            r.lo    <= {`LDM_SMIN, `LDM_SMIN, `LDM_SMIN, `LDM_UMIN, `LDM_SMIN};
            r.hi    <= {`LDM_SMAX, `LDM_SMAX, `LDM_SMAX, `LDM_UMAX, `LDM_SMAX};
            r.vhi   <= `LDM_VHI_RST;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata            = r.rdata;
    assign tdr_owns_drivers     = r.tctl[`LDM_TC_EN];
    assign pulse_on_rx_pair     = r.tctl[`LDM_TC_TXRX];
    assign monitor_rx_pair      = r.tctl[`LDM_TC_MONRX];
    assign slow_line_driver     = r.dslow;
    assign fast_line_driver_pos = r.dpos;
    assign fast_line_driver_neg = r.dneg;
    assign adapt_restart        = r.restart;
    assign link_drop            = r.drop;
    assign lq_irq               = r.irq;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_send;
        start;
    endsequence
    sequence s_vlo;
        reg_re && (reg_addr == `LDM_A_VDATA) && !r.vhalf;
    endsequence
    property p_send_timer;
        @(posedge clock) disable iff (rst) s_send |=> (r.ts == TDR_RUN) && (r.tmr == 8'h00);
    endproperty
    a_send_timer: assert property (p_send_timer) else $error("timer not started");
    property p_stop;
        @(posedge clock) disable iff (rst)
            (r.ts == TDR_RUN) && (r.tmr == r.twin[7:0]) && !start |=> r.ts == TDR_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("timer ran past stop");
    property p_hold;
        @(posedge clock) disable iff (rst)
            (r.ts == TDR_IDLE) && !start |=> $stable(r.peak) && $stable(r.cross_t);
    endproperty
    a_hold: assert property (p_hold) else $error("results changed while idle");
    property p_zero_w;
        @(posedge clock) disable iff (rst) s_send ##0 (wdth == 3'h0)
            |=> !slow_line_driver && !fast_line_driver_pos && !fast_line_driver_neg
                && (r.ts == TDR_RUN);
    endproperty
    a_zero_w: assert property (p_zero_w) else $error("width zero drove pulse");
    property p_vhalves;
        @(posedge clock) disable iff (rst)
            s_vlo |=> (reg_rdata == $past(r.vsum[15:0])) && r.vhalf
                      && (r.vsnap == $past(r.vsum));
    endproperty
    a_vhalves: assert property (p_vhalves) else $error("variance low half wrong");
    property p_lq_en;
        @(posedge clock) disable iff (rst)
            reg_we && (reg_addr == `LDM_A_LQM) && (reg_wdata == 16'h8000) |=> r.lq_en;
    endproperty
    a_lq_en: assert property (p_lq_en) else $error("monitor not enabled");
    property p_equal;
        @(posedge clock) disable iff (rst)
            r.lq_en && (adaptive_gain == r.hi[1]) && !r.warn[3] |=> !r.warn[3];
    endproperty
    a_equal: assert property (p_equal) else $error("warning on equality");
    property p_drop;
        @(posedge clock) disable iff (rst)
            n.trg && !r.trg && !signal_detect_option |=> adapt_restart && link_drop;
    endproperty
    a_drop: assert property (p_drop) else $error("link not dropped");
    property p_sample;
        @(posedge clock) disable iff (rst)
            reg_we && (reg_addr == `LDM_A_LQD) && (reg_wdata == 16'h2400)
            |=> r.lqd == $past(baseline_wander);
    endproperty
    a_sample: assert property (p_sample) else $error("sampled value wrong");
    property p_irq_clr;
        @(posedge clock) disable iff (rst)
            reg_re && (reg_addr == `LDM_A_LQM) && !(r.lq_en && |viol) |=> !lq_irq;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
endmodule : ldm_monitor

/* verification/link_diagnostics_monitor_test.sv */
`include "ldm_defs.svh"
module link_diagnostics_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ldm_pkg::*;
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", n, e, a); end end
    // ****************************************
    // Stimulus and model state
    // ****************************************
    localparam int MSC = 10;
    logic        clock     = 1'b0;
    logic        rst       = 1'b1;
    logic        reg_we    = 1'b0;
    logic        reg_re    = 1'b0;
    logic        sdo       = 1'b0;
    logic [4:0]  reg_addr  = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, rd_v, lo_v;
    logic [7:0]  err_sq    = 8'h00;
    logic [7:0]  adc       = 8'h00;
    logic [7:0]  lfsr      = 8'h34;
    logic [7:0]  p [5]     = '{default: 8'h00};
    logic        owns, slow, fpos, fneg, rxp, mrx, rstr, drop, irq;
    int          fail_count = 0;
    int          cmp_count  = 0;
    int          n_slow, n_pos, n_neg, n_rst, n_drop, i, e;
    int          wd [3] = '{3, 5, 0};
    int          ws [3] = '{5, 10, 0};
    int          thr_m [12];
    int          exp_q [$];

    always #5 clock = ~clock;
    // Counted just after the edge so the falling-edge clear never races it
    always @(posedge clock) #1 begin
        n_slow += int'(slow);
        n_pos  += int'(fpos);
        n_neg  += int'(fneg);
        n_rst  += int'(rstr);
        n_drop += int'(drop);
    end

    ldm_monitor #(.MS_CYC(MSC)) DUT (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .rx_err_sq(err_sq),
        .equalizer_coefficient(p[0]), .adaptive_gain(p[1]), .baseline_wander(p[2]),
        .long_term_frequency_offset(p[3]), .frequency_control_value(p[4]),
        .adc_sample(adc), .signal_detect_option(sdo), .tdr_owns_drivers(owns),
        .slow_line_driver(slow), .fast_line_driver_pos(fpos),
        .fast_line_driver_neg(fneg), .pulse_on_rx_pair(rxp), .monitor_rx_pair(mrx),
        .adapt_restart(rstr), .link_drop(drop), .lq_irq(irq));

    // ****************************************
    // Bus tasks
    // ****************************************
    function automatic logic [7:0] nxt(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nxt
    // Reference warning bits: strict compares against the modelled thresholds
    function automatic int warn_m();
        int w;
        int v;
        w = 0;
        for (int k = 0; k < 5; k++) begin
            v = (k == 1) ? int'(p[k]) : int'($signed(p[k]));
            if (v < thr_m[2 * k]) w = w | (1 << (2 * k));
            if (v > thr_m[2 * k + 1]) w = w | (1 << (2 * k + 1));
        end
        return w;
    endfunction : warn_m
    task automatic wr(logic [4:0] a, logic [15:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(negedge clock);
        reg_we = 1'b0;
    endtask : wr
    // Sampled one cycle late: data holds until the next read anyway
    task automatic rd(logic [4:0] a);
        @(negedge clock);
        reg_addr = a;
        reg_re = 1'b1;
        @(negedge clock);
        reg_re = 1'b0;
        @(negedge clock);
        rd_v = reg_rdata;
    endtask : rd
    task automatic zc;
        @(negedge clock);
        {n_slow, n_pos, n_neg, n_rst, n_drop} = '0;
    endtask : zc
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(negedge clock);
        rst = 1'b0;
        rd(`LDM_A_TWIN);
        `CHK("window", `LDM_WIN_RST, rd_v)
        rd(5'h10);
        `CHK("unmapped", 16'h0000, rd_v)
        `CHK("pairs", 2'b00, {rxp, mrx})
        for (i = 0; i < 12; i++) begin
            wr(`LDM_A_LQD, 16'((i / 2) << 9) | 16'((i % 2) << 8));
            rd(`LDM_A_LQD);
            if (i < 10) thr_m[i] = (i / 2 == 1) ? ((i % 2) ? 255 : 0) : ((i % 2) ? 127 : -128);
            exp_q.push_back((i > 9) ? ((i % 2) ? 9 : 0) : (thr_m[i] & 255));
            e = exp_q.pop_front();
            `CHK("threshold", 16'(e), rd_v)
        end
        $display("reset test done");
        for (i = 0; i < 5; i++) begin
            p[i] = lfsr;
            lfsr = nxt(lfsr);
            wr(`LDM_A_LQD, 16'h2000 | 16'(i << 9));
            rd(`LDM_A_LQD);
            `CHK("sample", {8'h00, p[i]}, rd_v)
        end
        $display("sample test done");
        p[1] = 8'h40;
        p[2] = 8'hDA;
        wr(`LDM_A_LQD, 16'h1340);
        thr_m[3] = 64;
        wr(`LDM_A_LQD, 16'h14DA);
        thr_m[4] = -38;
        wr(`LDM_A_LQM, 16'h8000);
        zc();
        rd(`LDM_A_LQM);
        e = 16'h8000 | warn_m();
        `CHK("equal", 16'(e), rd_v)
        p[1] = 8'h41;
        p[2] = 8'hD9;
        exp_q.push_back(16'hC000 | warn_m());
        repeat (3) @(negedge clock);
        `CHK("irq", 1'b1, irq)
        p[1] = 8'h40;
        p[2] = 8'hDA;
        rd(`LDM_A_LQM);
        e = exp_q.pop_front();
        `CHK("warn", 16'(e), rd_v)
        rd(`LDM_A_LQM);
        `CHK("cleared", 16'h8000, rd_v)
        `CHK("irq off", 1'b0, irq)
        `CHK("no restart", 0, n_rst)
        for (i = 0; i < 2; i++) begin
            sdo = i[0];
            wr(`LDM_A_LQM2, 16'h0400);
            zc();
            p[2] = 8'hD9;
            repeat (6) @(negedge clock);
            p[2] = 8'hDA;
            repeat (2) @(negedge clock);
            `CHK("restart", 1, n_rst)
            `CHK("drop", 1 - i, n_drop)
        end
        $display("quality test done");
        err_sq = 8'h90;
        for (i = 0; i < 4; i++) begin
            wr(`LDM_A_VCTL, 16'h8000 | 16'(i));
            e = 0;
            repeat (100) if (e == 0) begin
                rd(`LDM_A_VCTL);
                e = int'(rd_v[`LDM_VC_DONE]);
            end
            if (e == 0) begin
                fail_count++;
                close_out();
            end
            rd(`LDM_A_VDATA);
            lo_v = rd_v;
            rd(`LDM_A_VDATA);
            `CHK("sum", 32'((i + 1) * 2 * MSC * 144), {rd_v, lo_v})
        end
        $display("variance test done");
        wr(`LDM_A_TWIN, 16'h0214);
        wr(`LDM_A_TTHR, 16'h0008);
        adc = 8'h10;
        wr(`LDM_A_TCTL, 16'h8000);
        `CHK("owner", 1'b1, owns)
        for (i = 0; i < 3; i++) begin
            if (i == 2) adc = 8'h20;
            zc();
            wr(`LDM_A_TCTL, 16'h8800 | 16'(wd[i] << 8));
            repeat (30) @(negedge clock);
            `CHK("slow", ws[i], n_slow)
            rd(`LDM_A_TPEAK);
            `CHK("peak", {8'h02, adc}, rd_v)
        end
        rd(`LDM_A_TTHR);
        `CHK("crossing", 16'h0208, rd_v)
        adc = 8'h7F;
        repeat (10) @(negedge clock);
        rd(`LDM_A_TPEAK);
        `CHK("held", 16'h0220, rd_v)
        zc();
        wr(`LDM_A_TCTL, 16'hCB00);
        repeat (20) @(negedge clock);
        e = n_pos;
        `CHK("fast", 3, n_pos + n_neg)
        zc();
        wr(`LDM_A_TCTL, 16'hCB00);
        repeat (20) @(negedge clock);
        `CHK("alternate", 3 - e, n_pos)
        adc = 8'hF0;
        wr(`LDM_A_TCTL, 16'hB880);
        repeat (30) @(negedge clock);
        `CHK("pairs", 2'b11, {rxp, mrx})
        rd(`LDM_A_TPEAK);
        `CHK("min", 16'h02F0, rd_v)
        wr(`LDM_A_TCTL, 16'h0000);
        `CHK("release", 1'b0, owns)
        $display("reflect test done");
        close_out();
    end
endmodule : link_diagnostics_monitor_test
